//--- include/drcrs_pkg.sv
package drcrs_pkg;
   // sequencer states, binary codes written out
   typedef enum logic [3:0] {
      DRCRS_IDLE   = 4'h0,
      DRCRS_ROW    = 4'h1,
      DRCRS_COL    = 4'h2,
      DRCRS_XWAIT  = 4'h3,
      DRCRS_HOLD   = 4'h4,
      DRCRS_RF1    = 4'h5,
      DRCRS_RF2    = 4'h6,
      DRCRS_RF3    = 4'h7,
      DRCRS_END    = 4'h8
   } drcrs_state_e;
   localparam int DRCRS_SYNC_STAGES = 2;
   localparam int DRCRS_NUM_PINS = 8;
   // pin order inside the synchroniser bus
   localparam int DRCRS_P_SEL = 0;
   localparam int DRCRS_P_ALE = 1;
   localparam int DRCRS_P_WIN = 2;
   localparam int DRCRS_P_REQ = 3;
   localparam int DRCRS_P_XW = 4;
   localparam int DRCRS_P_LAB = 5;
   localparam int DRCRS_P_UHE = 6;
   localparam int DRCRS_P_OE = 7;
   // idle pin levels, so no false select or refresh right after reset
   localparam logic [DRCRS_NUM_PINS-1:0] DRCRS_PIN_RST = 8'hCD;
endpackage

//--- include/drcrs_sync_if.sv
`timescale 1ns/10ps
interface drcrs_sync_if #(parameter int W = 8);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface

//--- logic/drcrs_sync.sv
`timescale 1ns/10ps
module drcrs_sync
   import drcrs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   drcrs_sync_if.dst pins
);
   logic [DRCRS_NUM_PINS-1:0] stage1_ff;
   logic [DRCRS_NUM_PINS-1:0] stage2_ff;
   logic [DRCRS_NUM_PINS-1:0] nxt_stage1;
   logic [DRCRS_NUM_PINS-1:0] nxt_stage2;
   always_comb
   begin
      nxt_stage1 = clk_en ? pins.raw : stage1_ff;
      nxt_stage2 = clk_en ? stage1_ff : stage2_ff;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage1_ff <= DRCRS_PIN_RST;
         stage2_ff <= DRCRS_PIN_RST;
      end
      else
      begin
         stage1_ff <= nxt_stage1;
         stage2_ff <= nxt_stage2;
      end
   end
   assign pins.synced = stage2_ff;
endmodule // drcrs_sync

//--- logic/drcrs_top.sv
`timescale 1ns/10ps
// Contract
// - select plus ALE starts cycle, row strobe
// - column strobes after row phase, byte-wise
// - upper gated by high enable, lower by address
// - hidden refresh on unselected bus cycle
// - no column strobes during refresh
// - forced refresh when idle, window low
// - access during forced refresh waits
// - refresh output clears pending request
// - refresh output low during refresh
// - extra wait select adds one cycle
// - no extra wait in hidden refresh
// - no waits normally, forced up to three
module drcrs_top
   import drcrs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic mem_select_b,
   input wire logic ale,
   input wire logic refresh_window_clock,
   input wire logic refresh_request_b,
   input wire logic extra_wait_select,
   input wire logic low_address_bit,
   input wire logic byte_high_enable_b,
   input wire logic out_enable_b,
   output logic row_strobe_request,
   output logic row_strobe_request_oe,
   output logic column_strobe_upper_b,
   output logic column_strobe_upper_b_oe,
   output logic column_strobe_lower_b,
   output logic column_strobe_lower_b_oe,
   output logic ready,
   output logic ready_oe,
   output logic refresh_mode_out_b,
   output logic refresh_mode_out_b_oe
);
   import drcrs_pkg::*;

   drcrs_sync_if #(.W(DRCRS_NUM_PINS)) sync_bus ();
   logic [DRCRS_NUM_PINS-1:0] s;
   logic sel;
   logic ale_s;
   logic win;
   logic req;
   logic xwait;
   logic lab_s;
   logic uhe_s;
   logic oe_s;

   assign sync_bus.raw = {out_enable_b, byte_high_enable_b, low_address_bit,
      extra_wait_select, refresh_request_b, refresh_window_clock, ale,
      mem_select_b};

   drcrs_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .pins(sync_bus.dst)
   );

   assign s = sync_bus.synced;
   assign sel = ~s[DRCRS_P_SEL];
   assign ale_s = s[DRCRS_P_ALE];
   assign win = s[DRCRS_P_WIN];
   assign req = ~s[DRCRS_P_REQ];
   assign xwait = s[DRCRS_P_XW];
   assign lab_s = s[DRCRS_P_LAB];
   assign uhe_s = ~s[DRCRS_P_UHE];
   assign oe_s = ~s[DRCRS_P_OE];

   drcrs_state_e state_ff;
   drcrs_state_e nxt_state;
   logic pend_ff;
   logic nxt_pend;
   logic lane_hi_ff;
   logic nxt_lane_hi;
   logic lane_lo_ff;
   logic nxt_lane_lo;
   logic ras_ff;
   logic nxt_ras;
   logic col_hi_b_ff;
   logic nxt_col_hi_b;
   logic col_lo_b_ff;
   logic nxt_col_lo_b;
   logic rdy_ff;
   logic nxt_rdy;
   logic rmode_b_ff;
   logic nxt_rmode_b;
   logic oe_ff;
   logic nxt_oe;
   logic start_acc;
   logic in_refresh;
   logic forced_ff;
   logic nxt_forced;

   assign start_acc = sel && ale_s;
   assign in_refresh = (state_ff == DRCRS_RF1) || (state_ff == DRCRS_RF2)
      || (state_ff == DRCRS_RF3);

   // pending access captured while a forced refresh runs
   always_comb
   begin
      nxt_state = state_ff;
      nxt_pend = pend_ff;
      nxt_lane_hi = lane_hi_ff;
      nxt_lane_lo = lane_lo_ff;
      nxt_forced = forced_ff;
      case (state_ff)
         DRCRS_IDLE:
         begin
            if (start_acc)
            begin
               nxt_state = DRCRS_ROW;
               nxt_lane_hi = uhe_s;
               nxt_lane_lo = ~lab_s;
            end
            else if (req && win && !sel && ale_s)
            begin
               nxt_state = DRCRS_RF1;
               nxt_forced = 1'b0;
            end
            else if (req && !win)
            begin
               nxt_state = DRCRS_RF1;
               nxt_forced = 1'b1;
            end
         end
         DRCRS_ROW:
            nxt_state = xwait ? DRCRS_XWAIT : DRCRS_COL;
         DRCRS_XWAIT:
            nxt_state = DRCRS_COL;
         DRCRS_COL:
            nxt_state = DRCRS_HOLD;
         DRCRS_HOLD:
            nxt_state = DRCRS_END;
         DRCRS_RF1:
         begin
            nxt_state = DRCRS_RF2;
            if (start_acc && forced_ff)
            begin
               nxt_pend = 1'b1;
               nxt_lane_hi = uhe_s;
               nxt_lane_lo = ~lab_s;
            end
         end
         DRCRS_RF2:
         begin
            nxt_state = DRCRS_RF3;
            if (start_acc && forced_ff)
            begin
               nxt_pend = 1'b1;
               nxt_lane_hi = uhe_s;
               nxt_lane_lo = ~lab_s;
            end
         end
         DRCRS_RF3:
         begin
            // pending access, or one arriving now, runs straight after
            if (pend_ff || (start_acc && forced_ff))
            begin
               nxt_state = DRCRS_ROW;
               nxt_pend = 1'b0;
               if (!pend_ff)
               begin
                  nxt_lane_hi = uhe_s;
                  nxt_lane_lo = ~lab_s;
               end
            end
            else
               nxt_state = DRCRS_END;
         end
         DRCRS_END:
         begin
            // a four-clock host cycle may strobe ale here; else it is lost
            if (start_acc)
            begin
               nxt_state = DRCRS_ROW;
               nxt_lane_hi = uhe_s;
               nxt_lane_lo = ~lab_s;
            end
            else
               nxt_state = DRCRS_IDLE;
         end
         default:
            nxt_state = DRCRS_IDLE;
      endcase
   end

   // outputs registered from next state; output enables from the synced oe pin
   always_comb
   begin
      nxt_ras = (nxt_state == DRCRS_ROW) || (nxt_state == DRCRS_XWAIT)
         || (nxt_state == DRCRS_COL) || (nxt_state == DRCRS_HOLD)
         || (nxt_state == DRCRS_RF1) || (nxt_state == DRCRS_RF2)
         || (nxt_state == DRCRS_RF3);
      nxt_col_hi_b = 1'b1;
      nxt_col_lo_b = 1'b1;
      if ((nxt_state == DRCRS_COL) || (nxt_state == DRCRS_HOLD))
      begin
         nxt_col_hi_b = ~nxt_lane_hi;
         nxt_col_lo_b = ~nxt_lane_lo;
      end
      // refresh states never reach the column assignments above
      nxt_rmode_b = !((nxt_state == DRCRS_RF1) || (nxt_state == DRCRS_RF2)
         || (nxt_state == DRCRS_RF3));
      // ready dropped only for the extra wait or a held access
      nxt_rdy = !((nxt_state == DRCRS_XWAIT) || nxt_pend
         || (in_refresh && forced_ff && start_acc));
      nxt_oe = oe_s;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= DRCRS_IDLE;
         pend_ff <= 1'b0;
         lane_hi_ff <= 1'b0;
         lane_lo_ff <= 1'b0;
         forced_ff <= 1'b0;
         ras_ff <= 1'b0;
         col_hi_b_ff <= 1'b1;
         col_lo_b_ff <= 1'b1;
         rdy_ff <= 1'b1;
         rmode_b_ff <= 1'b1;
         oe_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         state_ff <= nxt_state;
         pend_ff <= nxt_pend;
         lane_hi_ff <= nxt_lane_hi;
         lane_lo_ff <= nxt_lane_lo;
         forced_ff <= nxt_forced;
         ras_ff <= nxt_ras;
         col_hi_b_ff <= nxt_col_hi_b;
         col_lo_b_ff <= nxt_col_lo_b;
         rdy_ff <= nxt_rdy;
         rmode_b_ff <= nxt_rmode_b;
         oe_ff <= nxt_oe;
      end
   end

   assign row_strobe_request = ras_ff;
   assign column_strobe_upper_b = col_hi_b_ff;
   assign column_strobe_lower_b = col_lo_b_ff;
   assign ready = rdy_ff;
   assign refresh_mode_out_b = rmode_b_ff;
   // state keeps running while the pins float
   assign row_strobe_request_oe = oe_ff;
   assign column_strobe_upper_b_oe = oe_ff;
   assign column_strobe_lower_b_oe = oe_ff;
   assign ready_oe = oe_ff;
   assign refresh_mode_out_b_oe = oe_ff;
endmodule // drcrs_top

//--- tb/drcrs_top_monitor.sv
`timescale 1ns/10ps
module drcrs_top_monitor
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic out_enable_b,
   input wire logic row_strobe_request,
   input wire logic column_strobe_upper_b,
   input wire logic column_strobe_lower_b,
   input wire logic ready,
   input wire logic ready_oe,
   input wire logic refresh_mode_out_b
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_cas;
      !column_strobe_upper_b [*2] ##1 column_strobe_upper_b;
   endsequence
   sequence s_lo;
      !column_strobe_lower_b [*2] ##1 column_strobe_lower_b;
   endsequence
   sequence s_rf3;
      !refresh_mode_out_b [*3] ##1 refresh_mode_out_b;
   endsequence
   a_cas_width: assert property ($fell(column_strobe_upper_b) |-> s_cas)
      else $error("upper strobe width wrong");
   a_low_width: assert property ($fell(column_strobe_lower_b) |-> s_lo)
      else $error("lower strobe width wrong");
   a_no_cas_rf: assert property (!refresh_mode_out_b |->
      column_strobe_upper_b && column_strobe_lower_b)
      else $error("column strobe during refresh");
   a_cas_in_ras: assert property (!(column_strobe_upper_b
      && column_strobe_lower_b) |-> row_strobe_request)
      else $error("column strobe without row strobe");
   a_rf_len: assert property ($fell(refresh_mode_out_b) |-> s_rf3)
      else $error("refresh length wrong");
   a_rf_ras: assert property (!refresh_mode_out_b |-> row_strobe_request)
      else $error("refresh without row strobe");
   a_idle_off: assert property ($fell(row_strobe_request) |->
      column_strobe_upper_b && column_strobe_lower_b)
      else $error("strobes left on at idle");
   a_wait_bound: assert property ($fell(ready) |-> ##[1:3] ready)
      else $error("ready held low too long");
   a_oe_lag: assert property ($rose(ready_oe) |-> !$past(out_enable_b, 3))
      else $error("output enable rose without cause");
endmodule // drcrs_top_monitor

bind drcrs_top drcrs_top_monitor i_drcrs_top_monitor (
   .clk(clk),
   .rst_b(rst_b),
   .out_enable_b(out_enable_b),
   .row_strobe_request(row_strobe_request),
   .column_strobe_upper_b(column_strobe_upper_b),
   .column_strobe_lower_b(column_strobe_lower_b),
   .ready(ready),
   .ready_oe(ready_oe),
   .refresh_mode_out_b(refresh_mode_out_b)
);

//--- tb/drcrs_refresh_latch.sv
`timescale 1ns/10ps
module drcrs_refresh_latch
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic need_refresh,
   input wire logic refresh_mode_out_b,
   output logic refresh_request_b
);
   logic req_ff;
   logic nxt_req;
   // interval counter left to the bench; clear wins over set
   always_comb
   begin
      nxt_req = req_ff | need_refresh;
      if (!refresh_mode_out_b)
         nxt_req = 1'b0;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         req_ff <= 1'b0;
      else
         req_ff <= nxt_req;
   end
   assign refresh_request_b = !req_ff;
endmodule // drcrs_refresh_latch

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, mem_select_b = 1'b1;
   logic ale = 1'b0, refresh_window_clock = 1'b1, extra_wait_select = 1'b0;
   logic low_address_bit = 1'b0, byte_high_enable_b = 1'b0;
   logic out_enable_b = 1'b0, need_refresh = 1'b0, refresh_request_b;
   logic row_strobe_request, row_strobe_request_oe, ready, ready_oe;
   logic column_strobe_upper_b, column_strobe_upper_b_oe;
   logic column_strobe_lower_b, column_strobe_lower_b_oe;
   logic refresh_mode_out_b, refresh_mode_out_b_oe, cu, cl, rf;
   logic [7:0] n_wait, n_ras;
   int n_fail = 0, checks_done = 0;
   always #50 clk = !clk;
   drcrs_top i_drcrs_top (
      .clk(clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .mem_select_b(mem_select_b),
      .ale(ale),
      .refresh_window_clock(refresh_window_clock),
      .refresh_request_b(refresh_request_b),
      .extra_wait_select(extra_wait_select),
      .low_address_bit(low_address_bit),
      .byte_high_enable_b(byte_high_enable_b),
      .out_enable_b(out_enable_b),
      .row_strobe_request(row_strobe_request),
      .row_strobe_request_oe(row_strobe_request_oe),
      .column_strobe_upper_b(column_strobe_upper_b),
      .column_strobe_upper_b_oe(column_strobe_upper_b_oe),
      .column_strobe_lower_b(column_strobe_lower_b),
      .column_strobe_lower_b_oe(column_strobe_lower_b_oe),
      .ready(ready),
      .ready_oe(ready_oe),
      .refresh_mode_out_b(refresh_mode_out_b),
      .refresh_mode_out_b_oe(refresh_mode_out_b_oe)
   );
   drcrs_refresh_latch i_drcrs_refresh_latch (
      .clk(clk),
      .rst_b(rst_b),
      .need_refresh(need_refresh),
      .refresh_mode_out_b(refresh_mode_out_b),
      .refresh_request_b(refresh_request_b)
   );
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   // sampled at falling edge, well after the registered outputs settle
   task watch(input int n);
      repeat (n)
      begin
         @(negedge clk);
         n_wait = n_wait + {7'h00, ready !== 1'b1};
         n_ras = n_ras + {7'h00, row_strobe_request === 1'b1};
         cu = cu | !column_strobe_upper_b;
         cl = cl | !column_strobe_lower_b;
         rf = rf | !refresh_mode_out_b;
      end
   endtask
   task clr;
      n_wait = 8'h00;
      n_ras = 8'h00;
      {cu, cl, rf} = 3'h0;
   endtask
   task bus_cycle(input logic sel_b, input logic adr, input logic hi_b);
      @(negedge clk);
      mem_select_b = sel_b;
      ale = 1'b1;
      low_address_bit = adr;
      byte_high_enable_b = hi_b;
      watch(1);
      ale = 1'b0;
      watch(12);
      mem_select_b = 1'b1;
   endtask
   task t_lanes;
      for (int i = 0; i < 3; i++)
      begin
         clr;
         bus_cycle(1'b0, i[0], i[1]);
         chk("upper", {7'h00, !i[1]}, {7'h00, cu});
         chk("lower", {7'h00, !i[0]}, {7'h00, cl});
         chk("waits", 8'h00, n_wait);
         chk("ras len", 8'h03, n_ras);
      end
   endtask
   task t_xwait;
      extra_wait_select = 1'b1;
      clr;
      bus_cycle(1'b0, 1'b0, 1'b0);
      chk("xwait", 8'h01, n_wait);
      chk("x ras", 8'h04, n_ras);
      extra_wait_select = 1'b0;
   endtask
   task t_hidden;
      // extra wait on, so a wait leaking into hidden refresh would show
      extra_wait_select = 1'b1;
      clr;
      need_refresh = 1'b1;
      watch(1);
      need_refresh = 1'b0;
      watch(5);
      chk("no start", 8'h00, {7'h00, rf});
      bus_cycle(1'b1, 1'b0, 1'b0);
      chk("hidden", 8'h01, {7'h00, rf});
      chk("hid cas", 8'h00, {7'h00, cu | cl});
      chk("hid wait", 8'h00, n_wait);
      chk("req clr", 8'h01, {7'h00, refresh_request_b});
      chk("hid ras", 8'h03, n_ras);
      extra_wait_select = 1'b0;
   endtask
   task t_forced;
      refresh_window_clock = 1'b0;
      clr;
      need_refresh = 1'b1;
      watch(1);
      need_refresh = 1'b0;
      bus_cycle(1'b0, 1'b0, 1'b0);
      chk("forced", 8'h01, {7'h00, rf});
      chk("fwait", 8'h01, {7'h00, n_wait > 0 && n_wait < 4});
      chk("f cas", 8'h01, {7'h00, cu & cl});
      chk("f ras", 8'h06, n_ras);
      refresh_window_clock = 1'b1;
   endtask
   task t_freeze;
      clk_en = 1'b0;
      clr;
      bus_cycle(1'b0, 1'b0, 1'b0);
      clk_en = 1'b1;
      watch(4);
      chk("frozen", 8'h00, {7'h00, cu | cl});
      chk("frz ras", 8'h00, n_ras);
   endtask
   task t_oe;
      chk("oe on", 8'h1F, {3'h0, row_strobe_request_oe, ready_oe,
         column_strobe_upper_b_oe, column_strobe_lower_b_oe,
         refresh_mode_out_b_oe});
      out_enable_b = 1'b1;
      watch(5);
      chk("oe off", 8'h00, {3'h0, row_strobe_request_oe, ready_oe,
         column_strobe_upper_b_oe, column_strobe_lower_b_oe,
         refresh_mode_out_b_oe});
   endtask
   task wrap_up;
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      watch(3);
      t_lanes;
      t_xwait;
      t_hidden;
      t_forced;
      t_freeze;
      t_oe;
      wrap_up;
   end
   // whole run needs about 120 cycles
   initial
   begin
      #(5000 * 100);
      n_fail++;
      wrap_up;
   end
endmodule // tb
